/* File: hw/pms_buf2.sv */
`default_nettype none
module pms_buf2 #(
    parameter int W = 5,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // streams
    pms_stream_if.snk in_s,
    pms_stream_if.src out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // full stalls the source; empty hides stale words
    assign in_s.ready = (cnt_q != FULL);
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data = mem_q[rp_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb
    begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wp_q] = in_s.data;
            wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
        end
        if (pop)
            rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        mem_q <= mem_d;
        if (!i_rst_b)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : pms_buf2
`default_nettype wire

/* File: hw/pms_pins_top.sv */
`default_nettype none
module pms_pins_top #(
    parameter int BLINK_CYCLES = pms_pkg::PMS_BLINK_CYCLES
) (
    // clocks and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_TXC,
    // straps
    input wire logic I_MAC_SELECT_STRAP_HI,
    input wire logic I_MAC_SELECT_STRAP_LO,
    input wire logic I_PHY_CONFIG_STRAP_ZERO,
    // mac transmit pins
    input wire logic I_TX_EN,
    input wire logic [pms_pkg::PMS_NIB_W-1:0] I_TXD,
    output logic O_TX_CLK,
    output logic O_TX_CLK_OE,
    // mac receive pins
    output logic O_RXC,
    output logic [pms_pkg::PMS_NIB_W-1:0] O_RXD,
    output logic O_RX_CTL,
    output logic O_RX_ER,
    // shared lamp pin
    input wire logic I_STATUS_LAMP_OUT_I,
    output logic O_STATUS_LAMP_OUT_O,
    output logic O_STATUS_LAMP_OUT_OE,
    // core status
    input wire logic I_SPEED_100,
    input wire logic I_LINK_UP,
    input wire logic I_ACTIVITY,
    input wire logic I_CARRIER,
    input wire logic I_COLLISION,
    input wire logic [1:0] I_LAMP_MODE,
    // core receive stream
    input wire logic I_RX_VALID,
    input wire logic [pms_pkg::PMS_NIB_W-1:0] I_RX_DATA,
    input wire logic I_RX_ERR,
    output logic O_RX_READY,
    // core transmit words
    output logic O_TX_VALID,
    output logic [pms_pkg::PMS_NIB_W-1:0] O_TX_DATA,
    output logic O_TX_ERR
);
    import pms_pkg::*;

    localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYCLES - 1);

    // ------------------------------------------------------------
    // link domain: rgmii transmit capture
    // ------------------------------------------------------------
    logic lrst_s1_q, lrst_s2_q;
    logic len_q, len_d, lfall_q;
    logic [PMS_NIB_W-1:0] ltxd_q, ltxd_d;
    logic lreq_q, lreq_d;
    logic [PMS_WORD_W-1:0] lword_q, lword_d;
    logic lack_s1_q, lack_s2_q;
    logic ack_q, ack_d;

    always_comb
    begin
        len_d = I_TX_EN;
        ltxd_d = I_TXD;
        lreq_d = lreq_q;
        lword_d = lword_q;
        // words arriving while a handshake is open are dropped
        if (len_q && (lreq_q == lack_s2_q))
        begin
            lword_d = {len_q ^ lfall_q, ltxd_q};
            lreq_d = ~lreq_q;
        end
    end

    always_ff @(posedge I_TXC)
    begin
        lrst_s1_q <= I_RST_B;
        lrst_s2_q <= lrst_s1_q;
        lack_s1_q <= ack_q;
        lack_s2_q <= lack_s1_q;
        ltxd_q <= ltxd_d;
        lword_q <= lword_d;
        if (!lrst_s2_q)
        begin
            len_q <= 1'b0;
            lreq_q <= 1'b0;
        end
        else
        begin
            len_q <= len_d;
            lreq_q <= lreq_d;
        end
    end

    always_ff @(negedge I_TXC)
    begin
        lfall_q <= I_TX_EN;
    end

    // ------------------------------------------------------------
    // system domain: synchronisers and straps
    // ------------------------------------------------------------
    logic [8:0] pin_s1_q, pin_s2_q;
    logic req_s1_q, req_s2_q;
    logic sensed_q, sensed_d, eee_q, eee_d, lamp_low_q, lamp_low_d;
    pms_mode_t mode_q, mode_d;
    logic s_en, s_er, s_lamp;
    logic [PMS_NIB_W-1:0] s_txd;

    assign s_en = pin_s2_q[8];
    assign s_txd = pin_s2_q[7:4];
    assign s_lamp = pin_s2_q[3];
    assign s_er = pin_s2_q[3];

    function automatic pms_mode_t strap_mode(input logic [1:0] code);
        unique case (code)
            PMS_STRAP_MII: strap_mode = PMS_MODE_MII;
            PMS_STRAP_RMII: strap_mode = PMS_MODE_RMII;
            default: strap_mode = PMS_MODE_RGMII;
        endcase
    endfunction : strap_mode

    always_comb
    begin
        sensed_d = 1'b1;
        mode_d = mode_q;
        eee_d = eee_q;
        lamp_low_d = lamp_low_q;
        if (!sensed_q)
        begin
            mode_d = strap_mode(pin_s2_q[2:1]);
            eee_d = pin_s2_q[0];
            // pin pulled high while undriven means lamp to supply
            lamp_low_d = s_lamp;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        pin_s1_q <= {I_TX_EN, I_TXD, I_STATUS_LAMP_OUT_I, I_MAC_SELECT_STRAP_HI,
                     I_MAC_SELECT_STRAP_LO, I_PHY_CONFIG_STRAP_ZERO};
        pin_s2_q <= pin_s1_q;
        req_s1_q <= lreq_q;
        req_s2_q <= req_s1_q;
        if (!I_RST_B)
        begin
            sensed_q <= 1'b0;
            mode_q <= PMS_MODE_RGMII;
            eee_q <= 1'b0;
            lamp_low_q <= 1'b1;
        end
        else
        begin
            sensed_q <= sensed_d;
            mode_q <= mode_d;
            eee_q <= eee_d;
            lamp_low_q <= lamp_low_d;
        end
    end

    // ------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------
    pms_stream_if #(.W(PMS_WORD_W)) rx_in ();
    pms_stream_if #(.W(PMS_WORD_W)) rx_out ();

    assign rx_in.valid = I_RX_VALID;
    assign rx_in.data = {I_RX_ERR, I_RX_DATA};
    assign O_RX_READY = rx_in.ready;

    pms_buf2 #(.W(PMS_WORD_W), .DEPTH(2)) u_rx_buf (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .in_s(rx_in),
        .out_s(rx_out)
    );

    // ------------------------------------------------------------
    // system domain: clock divider, receive and transmit pins
    // ------------------------------------------------------------
    logic [7:0] cnt_q, cnt_d, half;
    logic tclk_q, tclk_d, wrap, rise, fall;
    logic dv_q, dv_d, er_q, er_d, ctl_q, ctl_d, dib_q, dib_d;
    logic [PMS_NIB_W-1:0] rxd_q, rxd_d, txo_q, txo_d;
    logic txv_q, txv_d, txe_q, txe_d;
    logic [23:0] blink_cnt_q, blink_cnt_d;
    logic blink_q, blink_d, lamp_on, col_pin, lamp_o_q, lamp_o_d, lamp_oe_q, lamp_oe_d;

    assign half = I_SPEED_100 ? PMS_HALF100 : PMS_HALF10;
    assign wrap = (cnt_q >= half - 8'h01);
    assign rise = wrap && !tclk_q;
    assign fall = wrap && tclk_q;
    assign rx_out.ready = rise && (mode_q != PMS_MODE_RMII || dib_q);
    assign col_pin = (mode_q == PMS_MODE_MII) && !eee_q;

    always_comb
    begin
        // divided from the reference so the edges track it
        cnt_d = wrap ? PMS_CNT_RST : cnt_q + 8'h01;
        tclk_d = wrap ? ~tclk_q : tclk_q;
        dv_d = dv_q;
        er_d = er_q;
        rxd_d = rxd_q;
        dib_d = dib_q;
        if (rise)
        begin
            dv_d = rx_out.valid;
            er_d = rx_out.valid && rx_out.data[PMS_WORD_ERR];
            dib_d = rx_out.valid && (mode_q == PMS_MODE_RMII) && !dib_q;
            if (!rx_out.valid)
                rxd_d = '0;
            else if (mode_q == PMS_MODE_RMII)
                rxd_d = dib_q ? {2'h0, rx_out.data[3:2]} : {2'h0, rx_out.data[1:0]};
            else
                rxd_d = rx_out.data[PMS_NIB_W-1:0];
        end
        unique case (mode_q)
            PMS_MODE_RGMII: ctl_d = rise ? dv_d : (fall ? (dv_q ^ er_q) : ctl_q);
            PMS_MODE_MII: ctl_d = dv_d;
            PMS_MODE_RMII: ctl_d = dv_d || I_CARRIER;
        endcase
        txv_d = 1'b0;
        txo_d = txo_q;
        txe_d = txe_q;
        ack_d = ack_q;
        if (mode_q == PMS_MODE_RGMII)
        begin
            if (req_s2_q != ack_q)
            begin
                ack_d = req_s2_q;
                txv_d = 1'b1;
                txo_d = lword_q[PMS_NIB_W-1:0];
                txe_d = lword_q[PMS_WORD_ERR];
            end
        end
        else if (rise && s_en)
        begin
            txv_d = 1'b1;
            txo_d = (mode_q == PMS_MODE_RMII) ? {2'h0, s_txd[1:0]} : s_txd;
            txe_d = (mode_q == PMS_MODE_MII) && eee_q && s_er;
        end
        blink_cnt_d = (blink_cnt_q >= BLINK_LAST) ? PMS_BLINK_RST : blink_cnt_q + 24'h000001;
        blink_d = (blink_cnt_q >= BLINK_LAST) ? ~blink_q : blink_q;
        unique case (I_LAMP_MODE)
            PMS_LAMP_LINK_ACT: lamp_on = I_LINK_UP && !(I_ACTIVITY && blink_q);
            PMS_LAMP_LINK: lamp_on = I_LINK_UP;
            PMS_LAMP_OFF: lamp_on = 1'b0;
            PMS_LAMP_ON: lamp_on = 1'b1;
        endcase
        lamp_o_d = col_pin ? I_COLLISION : (lamp_on ^ lamp_low_q);
        // pin floats until polarity is sensed; input when it carries tx error
        lamp_oe_d = sensed_q && !((mode_q == PMS_MODE_MII) && eee_q);
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_B)
        begin
            cnt_q <= PMS_CNT_RST;
            tclk_q <= 1'b0;
            dv_q <= 1'b0;
            er_q <= 1'b0;
            ctl_q <= 1'b0;
            dib_q <= 1'b0;
            rxd_q <= '0;
            txv_q <= 1'b0;
            txo_q <= '0;
            txe_q <= 1'b0;
            ack_q <= 1'b0;
            blink_cnt_q <= PMS_BLINK_RST;
            blink_q <= 1'b0;
            lamp_o_q <= 1'b0;
            lamp_oe_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tclk_q <= tclk_d;
            dv_q <= dv_d;
            er_q <= er_d;
            ctl_q <= ctl_d;
            dib_q <= dib_d;
            rxd_q <= rxd_d;
            txv_q <= txv_d;
            txo_q <= txo_d;
            txe_q <= txe_d;
            ack_q <= ack_d;
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
            lamp_o_q <= lamp_o_d;
            lamp_oe_q <= lamp_oe_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_TX_CLK = tclk_q;
    assign O_TX_CLK_OE = sensed_q && (mode_q == PMS_MODE_MII);
    assign O_RXC = tclk_q;
    assign O_RXD = rxd_q;
    assign O_RX_CTL = ctl_q;
    assign O_RX_ER = er_q;
    assign O_STATUS_LAMP_OUT_O = lamp_o_q;
    assign O_STATUS_LAMP_OUT_OE = lamp_oe_q;
    assign O_TX_VALID = txv_q;
    assign O_TX_DATA = txo_q;
    assign O_TX_ERR = txe_q;
endmodule : pms_pins_top
`default_nettype wire

/* File: shared/pms_pkg.sv */
`default_nettype none
package pms_pkg;
    // ------------------------------------------------------------
    // interface modes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PMS_MODE_RGMII = 3'b001,
        PMS_MODE_MII = 3'b010,
        PMS_MODE_RMII = 3'b100
    } pms_mode_t;

    // ------------------------------------------------------------
    // strap codes {hi, lo}
    // ------------------------------------------------------------
    localparam logic [1:0] PMS_STRAP_RGMII = 2'h0;
    localparam logic [1:0] PMS_STRAP_MII = 2'h1;
    localparam logic [1:0] PMS_STRAP_RMII = 2'h2;

    // ------------------------------------------------------------
    // word layout {err, nibble}
    // ------------------------------------------------------------
    localparam int PMS_NIB_W = 4;
    localparam int PMS_WORD_W = 5;
    localparam int PMS_WORD_ERR = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PMS_CLK_HZ = 10000000;
    localparam int PMS_TXCLK10_HZ = 2500000;
    localparam int PMS_TXCLK100_HZ = 25000000;
    localparam int PMS_HALF10_RAW = PMS_CLK_HZ / (2 * PMS_TXCLK10_HZ);
    localparam int PMS_HALF100_RAW = PMS_CLK_HZ / (2 * PMS_TXCLK100_HZ);
    // half periods cannot go below one system cycle
    localparam logic [7:0] PMS_HALF10 = 8'(PMS_HALF10_RAW < 1 ? 1 : PMS_HALF10_RAW);
    localparam logic [7:0] PMS_HALF100 = 8'(PMS_HALF100_RAW < 1 ? 1 : PMS_HALF100_RAW);
    localparam int PMS_BLINK_MS = 50;
    localparam int PMS_BLINK_CYCLES = (PMS_CLK_HZ / 1000) * PMS_BLINK_MS;

    // ------------------------------------------------------------
    // lamp modes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PMS_LAMP_LINK_ACT = 2'h0;
    localparam logic [1:0] PMS_LAMP_LINK = 2'h1;
    localparam logic [1:0] PMS_LAMP_OFF = 2'h2;
    localparam logic [1:0] PMS_LAMP_ON = 2'h3;
    localparam logic [7:0] PMS_CNT_RST = 8'h00;
    localparam logic [23:0] PMS_BLINK_RST = 24'h000000;
endpackage : pms_pkg
`default_nettype wire

/* File: shared/pms_stream_if.sv */
`default_nettype none
interface pms_stream_if #(parameter int W = 5);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pms_stream_if
`default_nettype wire

/* File: tb/pms_mac_model.sv */
`default_nettype none
module pms_mac_model (
    // mii clock from the block
    input wire logic i_tx_clk,
    // transmit pins
    output logic o_txc,
    output logic o_tx_en,
    output logic [pms_pkg::PMS_NIB_W-1:0] o_txd
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // free-running mac clock, so link-side reset sees edges
    // ----------------
    initial
    begin
        o_txc = 1'b0;
        o_tx_en = 1'b0;
        o_txd = 4'h0;
        #3.3;
        forever #7.5 o_txc = ~o_txc;
    end
    // idle data is driven back to zero after each word
    task automatic mii_word(input logic [3:0] d);
        @(posedge i_tx_clk);
        #1;
        o_tx_en = 1'b1;
        o_txd = d;
        @(posedge i_tx_clk);
        #1;
        o_tx_en = 1'b0;
        o_txd = 4'h0;
    endtask : mii_word
    task automatic rgmii_word(input logic [3:0] d, input logic e);
        @(posedge o_txc);
        #1;
        o_tx_en = 1'b1;
        o_txd = d;
        @(posedge o_txc);
        #1;
        o_tx_en = ~e;
        @(posedge o_txc);
        #1;
        o_tx_en = 1'b0;
        o_txd = 4'h0;
    endtask : rgmii_word
endmodule : pms_mac_model
`default_nettype wire

/* File: tb/pms_pins_top_checker.sv */
`default_nettype none
module pms_pins_top_checker #(
    parameter int BLINK_CYCLES = pms_pkg::PMS_BLINK_CYCLES
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // straps and core status
    input wire logic I_MAC_SELECT_STRAP_HI,
    input wire logic I_MAC_SELECT_STRAP_LO,
    input wire logic I_PHY_CONFIG_STRAP_ZERO,
    input wire logic I_STATUS_LAMP_OUT_I,
    input wire logic I_SPEED_100,
    input wire logic I_CARRIER,
    input wire logic I_COLLISION,
    input wire logic [1:0] I_LAMP_MODE,
    // pins
    input wire logic O_TX_CLK,
    input wire logic O_TX_CLK_OE,
    input wire logic O_RXC,
    input wire logic O_RX_CTL,
    input wire logic O_STATUS_LAMP_OUT_O,
    input wire logic O_STATUS_LAMP_OUT_OE,
    input wire logic O_RX_READY,
    input wire logic O_TX_VALID
);
    timeunit 1ns;
    timeprecision 100ps;
    import pms_pkg::*;
    // ----------------
    // mode seen at release
    // ----------------
    logic [1:0] up_q, up_d;
    logic mii_q, mii_d, rmii_q, rmii_d, eee_q, eee_d, pol_q, pol_d;
    logic up;
    always_comb
    begin
        up_d = up_q + 2'(up_q != 2'h3);
        {mii_d, rmii_d, eee_d, pol_d} = {mii_q, rmii_q, eee_q, pol_q};
        if (up_q == 2'h0)
        begin
            mii_d = {I_MAC_SELECT_STRAP_HI, I_MAC_SELECT_STRAP_LO} == PMS_STRAP_MII;
            rmii_d = {I_MAC_SELECT_STRAP_HI, I_MAC_SELECT_STRAP_LO} == PMS_STRAP_RMII;
            eee_d = I_PHY_CONFIG_STRAP_ZERO;
            pol_d = I_STATUS_LAMP_OUT_I;
        end
        if (!I_RST_B)
            up_d = 2'h0;
    end
    always_ff @(posedge I_CLK)
    begin
        up_q <= up_d;
        {mii_q, rmii_q, eee_q, pol_q} <= {mii_d, rmii_d, eee_d, pol_d};
    end
    // wait three edges so the enables have settled
    assign up = up_q == 2'h3;
    // ----------------
    // assertions
    // ----------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    clk_oe_mode_a: assert property (up |-> O_TX_CLK_OE == mii_q)
        else $error("tx clock enable wrong for mode");
    mode_held_a: assert property (up |-> $stable(O_TX_CLK_OE) && $stable(O_STATUS_LAMP_OUT_OE))
        else $error("pin function changed after reset");
    half_slow_a: assert property ($rose(O_TX_CLK) && !I_SPEED_100 |=> O_TX_CLK ##1 !O_TX_CLK)
        else $error("slow tx clock half period wrong");
    half_fast_a: assert property ($rose(O_TX_CLK) && I_SPEED_100 |=> !O_TX_CLK)
        else $error("fast tx clock half period wrong");
    clk_lock_a: assert property ($rose(O_TX_CLK) && !I_SPEED_100 |-> O_RXC ##4 $rose(O_TX_CLK))
        else $error("transmit clock drifted from reference");
    crs_merge_a: assert property (up && rmii_q && $past(I_CARRIER) |-> O_RX_CTL)
        else $error("carrier not merged into valid");
    col_out_a: assert property (up && mii_q && !eee_q |-> O_STATUS_LAMP_OUT_OE
        && O_STATUS_LAMP_OUT_O == $past(I_COLLISION))
        else $error("collision not on shared pin");
    txer_in_a: assert property (up && mii_q && eee_q |-> !O_STATUS_LAMP_OUT_OE)
        else $error("shared pin driven while it is an input");
    lamp_fixed_a: assert property (up && !mii_q && $past(I_LAMP_MODE) >= 2'h2 |->
        O_STATUS_LAMP_OUT_O == (($past(I_LAMP_MODE) == 2'h3) ^ pol_q))
        else $error("lamp level or polarity wrong");
    dv_edge_a: assert property (up && mii_q && $changed(O_RX_CTL) |-> $rose(O_RXC))
        else $error("receive valid moved off clock rise");
    cover property (up && mii_q && O_TX_VALID);
    cover property (up && !O_RX_READY);
    cover property (up && rmii_q && O_RX_CTL);
endmodule : pms_pins_top_checker
bind pms_pins_top pms_pins_top_checker #(.BLINK_CYCLES(BLINK_CYCLES)) pms_pins_top_checker_inst (
    .I_CLK, .I_RST_B, .I_MAC_SELECT_STRAP_HI, .I_MAC_SELECT_STRAP_LO, .I_PHY_CONFIG_STRAP_ZERO,
    .I_STATUS_LAMP_OUT_I, .I_SPEED_100, .I_CARRIER, .I_COLLISION, .I_LAMP_MODE, .O_TX_CLK,
    .O_TX_CLK_OE, .O_RXC, .O_RX_CTL, .O_STATUS_LAMP_OUT_O, .O_STATUS_LAMP_OUT_OE, .O_RX_READY,
    .O_TX_VALID
);
`default_nettype wire

/* File: tb/pms_pins_top_tb.sv */
`default_nettype none
module pms_pins_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pms_pkg::*;
    logic clk, rst_b, txc, s_hi, s_lo, eee, pull, spd, tx_en, link, act, carr, coll, lamp;
    logic rxv, rxe, rdy, txv, txe, txclk, txoe, rxc, rxctl, rxer, lo, loe;
    logic [1:0] lmode;
    logic [3:0] txd, rxdi, rxd, txdat;
    logic [4:0] txw;
    logic [4:0] rxq[$];
    int err_total, n_checks, n_tx, cyc;
    // last receive clock level, for rise detection at the sampling edge
    logic rxc_q;
    // board pull stands in when nobody drives the lamp pin
    assign lamp = loe ? lo : pull;
    pms_pins_top #(.BLINK_CYCLES(8)) pms_pins_top_inst (
        .I_CLK(clk), .I_RST_B(rst_b), .I_TXC(txc), .I_MAC_SELECT_STRAP_HI(s_hi),
        .I_MAC_SELECT_STRAP_LO(s_lo), .I_PHY_CONFIG_STRAP_ZERO(eee), .I_TX_EN(tx_en), .I_TXD(txd),
        .O_TX_CLK(txclk), .O_TX_CLK_OE(txoe), .O_RXC(rxc), .O_RXD(rxd), .O_RX_CTL(rxctl),
        .O_RX_ER(rxer), .I_STATUS_LAMP_OUT_I(lamp), .O_STATUS_LAMP_OUT_O(lo),
        .O_STATUS_LAMP_OUT_OE(loe), .I_SPEED_100(spd), .I_LINK_UP(link), .I_ACTIVITY(act),
        .I_CARRIER(carr), .I_COLLISION(coll), .I_LAMP_MODE(lmode), .I_RX_VALID(rxv),
        .I_RX_DATA(rxdi), .I_RX_ERR(rxe), .O_RX_READY(rdy), .O_TX_VALID(txv), .O_TX_DATA(txdat),
        .O_TX_ERR(txe)
    );
    pms_mac_model pms_mac_model_inst (.i_tx_clk(txclk), .o_txc(txc), .o_tx_en(tx_en), .o_txd(txd));
    // ----------------
    // clock, timeout, collectors
    // ----------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            close_out();
        end
    end
    always @(negedge clk)
    begin
        if (rxc && !rxc_q && rxctl)
            rxq.push_back({rxer, rxd});
        rxc_q <= rxc;
        if (txv)
        begin
            n_tx++;
            txw = {txe, txdat};
        end
    end
    // ----------------
    // shared tasks
    // ----------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic do_rst(input logic [1:0] sc, input logic e, input logic p, input logic s);
        tick(1);
        rst_b = 1'b0;
        {s_hi, s_lo} = sc;
        {eee, pull, spd} = {e, p, s};
        tick(3);
        rst_b = 1'b1;
        tick(4);
        rxq.delete();
        n_tx = 0;
    endtask : do_rst
    task automatic push(input logic [4:0] ws[$], output int nref);
        logic tk;
        nref = 0;
        rxv = 1'b1;
        foreach (ws[i])
        begin
            {rxe, rxdi} = ws[i];
            do
            begin
                @(negedge clk);
                tk = rdy;
                nref += int'(!tk);
                tick(1);
            end while (!tk);
        end
        rxv = 1'b0;
    endtask : push
    task automatic wait_rx(input int n);
        for (int i = 0; i < 200 && rxq.size() < n; i++)
            tick(1);
    endtask : wait_rx
    // ----------------
    // scenarios
    // ----------------
    task automatic t_mii_rx;
        logic [4:0] w[$];
        int nref;
        w = '{5'h03, 5'h1c, 5'h0a, 5'h11};
        do_rst(PMS_STRAP_MII, 1'b0, 1'b1, 1'b0);
        push(w, nref);
        chk("buffer refusal", 8'h1, 8'(nref > 0));
        wait_rx(4);
        foreach (w[i]) chk("mii rx word", 8'(w[i]), 8'(rxq[i]));
        tick(12);
        chk("rx valid idle", 8'h0, 8'(rxctl));
        coll = 1'b1;
        {s_hi, s_lo} = PMS_STRAP_RMII;
        tick(3);
        chk("collision out", 8'h1, 8'(lo));
        chk("mode held", 8'h1, 8'(txoe));
        coll = 1'b0;
        tick(3);
        chk("collision cleared", 8'h0, 8'(lo));
        $display("mii receive test done");
    endtask : t_mii_rx
    task automatic t_tx;
        do_rst(PMS_STRAP_MII, 1'b0, 1'b1, 1'b0);
        pms_mac_model_inst.mii_word(4'h6);
        tick(20);
        chk("mii tx count", 8'h1, 8'(n_tx));
        chk("mii tx word", 8'h06, 8'(txw));
        do_rst(PMS_STRAP_MII, 1'b1, 1'b1, 1'b1);
        pms_mac_model_inst.mii_word(4'h5);
        tick(20);
        chk("tx error in", 8'h15, 8'(txw));
        chk("shared pin free", 8'h0, 8'(loe));
        do_rst(PMS_STRAP_RGMII, 1'b0, 1'b1, 1'b0);
        pms_mac_model_inst.rgmii_word(4'ha, 1'b1);
        tick(20);
        chk("rgmii tx count", 8'h1, 8'(n_tx));
        chk("rgmii tx word", 8'h1a, 8'(txw));
        $display("transmit test done");
    endtask : t_tx
    task automatic t_rg_rx;
        int nref;
        do_rst(PMS_STRAP_RGMII, 1'b0, 1'b1, 1'b0);
        push('{5'h15}, nref);
        wait_rx(1);
        chk("rgmii rx word", 8'h15, 8'(rxq[0]));
        for (int i = 0; i < 8 && rxc; i++)
            tick(1);
        chk("ctl low phase", 8'h0, 8'(rxctl));
        chk("rx error", 8'h1, 8'(rxer));
        $display("rgmii receive test done");
    endtask : t_rg_rx
    task automatic t_rmii;
        int nref;
        do_rst(PMS_STRAP_RMII, 1'b0, 1'b1, 1'b1);
        push('{5'h09}, nref);
        wait_rx(2);
        chk("rmii low dibit", 8'h01, 8'(rxq[0]));
        chk("rmii high dibit", 8'h02, 8'(rxq[1]));
        carr = 1'b1;
        tick(3);
        chk("carrier merge", 8'h1, 8'(rxctl));
        carr = 1'b0;
        $display("rmii test done");
    endtask : t_rmii
    task automatic t_lamp(input logic p);
        int ons;
        do_rst(PMS_STRAP_RGMII, 1'b0, p, 1'b0);
        link = 1'b0;
        for (int m = 1; m < 4; m++)
        begin
            lmode = 2'(m);
            tick(3);
            chk("lamp level", 8'((m == 3) ^ p), 8'(lo));
        end
        {lmode, link, act} = {2'h0, 1'b1, 1'b1};
        ons = 0;
        for (int i = 0; i < 40; i++)
        begin
            tick(1);
            ons += int'(lo ^ p);
        end
        chk("lamp blinks", 8'h1, 8'(ons > 0 && ons < 40));
        act = 1'b0;
        tick(20);
        chk("lamp steady", 8'(!p), 8'(lo));
        $display("lamp test done");
    endtask : t_lamp
    initial
    begin
        {rst_b, s_hi, s_lo, eee, pull, spd, link, act, carr, coll, rxv, rxe} = '0;
        {lmode, rxdi, err_total, n_checks, n_tx, cyc} = '0;
        t_mii_rx();
        t_tx();
        t_rg_rx();
        t_rmii();
        t_lamp(1'b0);
        t_lamp(1'b1);
        close_out();
    end
endmodule : pms_pins_top_tb
`default_nettype wire
